// ==== board_reset_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module board_reset_model (
    // clock
    input wire logic clk_i,
    // sequence request from the bench
    input wire logic go_i,
    input wire logic [1:0] mode_i,
    input wire logic [15:0] low_clks_i,
    // board pins and status
    output logic reset_pin_n_o,
    output logic boot_select_low_pin_o,
    output logic boot_select_high_pin_o,
    output logic busy_o
);
    ////////////////////////////////////////////////////////////////////////////////
    // supply valid: reset pin high, straps at rest
    initial begin
        reset_pin_n_o = 1'b1;
        {boot_select_high_pin_o, boot_select_low_pin_o} = 2'b00;
        busy_o = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // one reset pulse per request, straps driven only in their window
    always begin
        @(posedge clk_i);
        if (go_i === 1'b1) begin
            #1;
            busy_o = 1'b1;
            // straps undriven outside their window: show the inverse
            {boot_select_high_pin_o, boot_select_low_pin_o} = ~mode_i;
            repeat (4) @(posedge clk_i);
            #1 reset_pin_n_o = 1'b0;
            repeat (low_clks_i - 16'h0003) @(posedge clk_i);
            #1 {boot_select_high_pin_o, boot_select_low_pin_o} = mode_i;
            repeat (3) @(posedge clk_i);
            #1 reset_pin_n_o = 1'b1;
            repeat (12) @(posedge clk_i);
            #1 {boot_select_high_pin_o, boot_select_low_pin_o} = ~mode_i;
            busy_o = 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int W = 3,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // asynchronous pins and their synchronised copies
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    // width check
    if (W < 1) begin : g_bad_w
        $error("synchroniser width must be at least 1");
    end

    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    // two-stage capture; only the second stage leaves the module
    always_comb begin
        next_meta = d_i;
        next_q = meta;
    end

    always_ff @(posedge clk_i) begin
        // reset to the idle level of each pin, so no false edge follows reset
        if (rst_i) begin
            meta <= RST_VAL;
            q_o <= RST_VAL;
        end else begin
            meta <= next_meta;
            q_o <= next_q;
        end
    end

endmodule
`default_nettype wire

// ==== reset_pll_boot_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
module reset_pll_boot_sequencer
    import reset_seq_pkg::*;
#(
    parameter int RAM_CHECK_CYC = RAM_CHECK_CYC_DEF,
    parameter int PLL_MULT = PLL_MULT_DEF
) (
    // clock (external_clock_input) and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // board pins
    input wire logic reset_pin_n_i,
    input wire logic boot_select_low_pin_i,
    input wire logic boot_select_high_pin_i,
    // boot engine handshake
    input wire logic boot_done_i,
    // reset and pll control
    output logic core_reset_o,
    output logic mem_clear_o,
    output logic pll_init_o,
    output logic pll_lock_wait_o,
    output logic pll_ready_o,
    output logic [MULT_W-1:0] pll_mult_o,
    output logic release_violation_o,
    // boot control
    output logic [1:0] boot_mode_o,
    output logic host_boot_o,
    output logic self_boot_o,
    output logic [15:0] boot_param_addr_o,
    output logic boot_error_o,
    output logic reload_needed_o,
    output logic ram_check_busy_o,
    output logic ram_check_done_o,
    // execution start
    output logic run_o,
    output logic [15:0] pc_entry_o
);

    ////////////////////////////////////////////////////////////////////////
    // parameter checks
    if (PLL_MULT < 1 || PLL_MULT > 16) begin : g_bad_mult
        $error("pll multiplier must be 1 to 16");
    end
    if (RAM_CHECK_CYC < 1 || RAM_CHECK_CYC >= (1 << TMR_W)) begin : g_bad_chk
        $error("ram check length out of range");
    end

    localparam logic [TMR_W-1:0] CHK_LAST = TMR_W'(RAM_CHECK_CYC - 1);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [2:0] pins;
    logic pin_n;
    logic [1:0] pin_mode;

    pin_sync #(.W(3), .RST_VAL(3'b100)) pin_sync_i ( // reset pin idles high
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({reset_pin_n_i, boot_select_high_pin_i, boot_select_low_pin_i}),
        .q_o(pins)
    );

    assign pin_n = pins[2];
    assign pin_mode = pins[1:0];

    // states in which the core is held in reset
    function automatic logic in_reset(input seq_state_t s);
        return (s == ST_COUNT) || (s == ST_PLL_INIT) || (s == ST_PLL_LOCK) || (s == ST_HOLD);
    endfunction

    // modes that run a real boot
    function automatic logic is_boot(input boot_mode_t m);
        return (m == BOOT_HOST) || (m == BOOT_SELF);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // sequencer state
    seq_state_t state, next_state;
    boot_mode_t mode, next_mode;
    logic pin_prev, next_pin_prev;
    logic [CNT_W-1:0] clk_cnt, next_clk_cnt;
    logic [TMR_W-1:0] tmr, next_tmr;
    logic [TMR_W-1:0] chk_cnt, next_chk_cnt;
    logic chk_done, next_chk_done;
    logic boot_fin, next_boot_fin;
    logic pll_ok, next_pll_ok;
    logic reload, next_reload;
    logic violation, next_violation;
    logic rel;

    assign rel = pin_n && !pin_prev;

    // next-state logic
    always_comb begin
        next_state = state;
        next_mode = mode;
        next_pin_prev = pin_n;
        next_tmr = tmr;
        next_chk_cnt = chk_cnt;
        next_chk_done = chk_done;
        next_boot_fin = boot_fin;
        next_pll_ok = pll_ok;
        next_reload = reload;
        next_violation = violation;
        if (!pin_n) begin
            next_clk_cnt = (clk_cnt == PLL_START_LAST) ? clk_cnt : clk_cnt + CNT_W'(1);
        end else begin
            next_clk_cnt = '0;
        end
        if (rel) begin
            next_mode = boot_mode_t'(pin_mode);
            next_boot_fin = 1'b0;
            next_chk_cnt = '0;
            next_chk_done = 1'b0;
        end
        unique case (state)
            ST_COUNT: begin
                if (rel) begin
                    next_state = ST_BOOT;
                end else if (!pin_n && clk_cnt == PLL_START_LAST) begin
                    next_state = ST_PLL_INIT;
                    next_tmr = '0;
                    next_pll_ok = 1'b0;
                    next_reload = 1'b1;
                end
            end
            ST_PLL_INIT: begin
                if (rel) begin
                    next_violation = 1'b1;
                    next_state = ST_BOOT;
                end else if (tmr == PLL_INIT_LAST) begin
                    next_state = ST_PLL_LOCK;
                    next_tmr = '0;
                end else begin
                    next_tmr = tmr + TMR_W'(1);
                end
            end
            ST_PLL_LOCK: begin
                if (rel) begin
                    next_violation = 1'b1;
                    next_state = ST_BOOT;
                end else if (tmr == PLL_LOCK_LAST) begin
                    next_state = ST_HOLD;
                    next_pll_ok = 1'b1;
                end else begin
                    next_tmr = tmr + TMR_W'(1);
                end
            end
            ST_HOLD: begin
                if (rel) begin
                    next_state = ST_BOOT;
                end
            end
            ST_BOOT: begin
                if (!pin_n) begin
                    next_state = ST_COUNT;
                end else if (mode == BOOT_SKIP) begin
                    next_state = ST_RUN;
                end else if (mode == BOOT_BAD) begin
                    next_state = ST_BAD;
                end else begin
                    if (!chk_done) begin
                        next_chk_cnt = chk_cnt + TMR_W'(1);
                        next_chk_done = (chk_cnt == CHK_LAST);
                    end
                    if (boot_done_i) begin
                        next_boot_fin = 1'b1;
                    end
                    if (boot_fin && chk_done) begin
                        next_state = ST_RUN;
                        next_reload = 1'b0;
                    end
                end
            end
            ST_RUN, ST_BAD: begin
                if (!pin_n) begin
                    next_state = ST_COUNT;
                end
            end
            default: begin
                next_state = ST_COUNT;
            end
        endcase
    end

    // state registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_COUNT;
            mode <= BOOT_SKIP;
            pin_prev <= 1'b1; // idle high: no release edge after reset
            clk_cnt <= '0;
            tmr <= '0;
            chk_cnt <= '0;
            chk_done <= 1'b0;
            boot_fin <= 1'b0;
            pll_ok <= 1'b0;
            reload <= 1'b0;
            violation <= 1'b0;
        end else begin
            state <= next_state;
            mode <= next_mode;
            pin_prev <= next_pin_prev;
            clk_cnt <= next_clk_cnt;
            tmr <= next_tmr;
            chk_cnt <= next_chk_cnt;
            chk_done <= next_chk_done;
            boot_fin <= next_boot_fin;
            pll_ok <= next_pll_ok;
            reload <= next_reload;
            violation <= next_violation;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered outputs, decoded from the next state
    logic next_core_reset, next_run, next_host, next_self, next_chk_busy;

    always_comb begin
        // core held while in reset states
        next_core_reset = in_reset(next_state);
        next_run = (next_state == ST_RUN);
        next_host = (next_state == ST_BOOT) && (next_mode == BOOT_HOST);
        next_self = (next_state == ST_BOOT) && (next_mode == BOOT_SELF);
        // check busy only during a real boot
        next_chk_busy = (next_state == ST_BOOT) && is_boot(next_mode) && !next_chk_done;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_reset_o <= 1'b1;
            mem_clear_o <= 1'b0;
            pll_init_o <= 1'b0;
            pll_lock_wait_o <= 1'b0;
            pll_ready_o <= 1'b0;
            pll_mult_o <= MULT_W'(1);
            release_violation_o <= 1'b0;
            boot_mode_o <= 2'h0;
            host_boot_o <= 1'b0;
            self_boot_o <= 1'b0;
            boot_param_addr_o <= ADDR_NONE;
            boot_error_o <= 1'b0;
            reload_needed_o <= 1'b0;
            ram_check_busy_o <= 1'b0;
            ram_check_done_o <= 1'b0;
            run_o <= 1'b0;
            pc_entry_o <= ADDR_NONE;
        end else begin
            core_reset_o <= next_core_reset;
            mem_clear_o <= (next_state == ST_PLL_INIT);
            pll_init_o <= (next_state == ST_PLL_INIT);
            pll_lock_wait_o <= (next_state == ST_PLL_LOCK);
            pll_ready_o <= next_pll_ok;
            // fixed multiplier once locked, else bypass
            pll_mult_o <= next_pll_ok ? MULT_W'(PLL_MULT) : MULT_W'(1);
            release_violation_o <= next_violation;
            boot_mode_o <= next_mode;
            host_boot_o <= next_host;
            self_boot_o <= next_self;
            boot_param_addr_o <= next_self ? BOOT_PARAM_ADDR : ADDR_NONE;
            boot_error_o <= (next_state == ST_BAD);
            reload_needed_o <= next_reload;
            ram_check_busy_o <= next_chk_busy;
            ram_check_done_o <= next_chk_done;
            run_o <= next_run;
            pc_entry_o <= next_run ? RESET_ENTRY : ADDR_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    AST_CNT_CLEAR: assert property (pin_n |=> clk_cnt == '0)
        else $error("low-clock count not cleared while reset high");
    AST_CORE_RST: assert property (!pin_n |=> core_reset_o)
        else $error("core not held while reset low");
    AST_PLL_START: assert property (state == ST_COUNT && !pin_n && clk_cnt == PLL_START_LAST
        |=> pll_init_o && mem_clear_o)
        else $error("pll setup did not start on the 1024th clock");
    AST_PLL_LOCK: assert property (state == ST_PLL_LOCK && !pin_n && tmr == PLL_LOCK_LAST
        |=> pll_ready_o && !pll_lock_wait_o && core_reset_o)
        else $error("lock wait did not end on time");
    AST_ORDINARY: assert property (state == ST_COUNT && rel |=> !pll_init_o ##1 !pll_init_o)
        else $error("early release entered pll setup");
    AST_ENTRY: assert property ($rose(run_o) |-> pc_entry_o == RESET_ENTRY && !core_reset_o)
        else $error("run started without reset entry");
    AST_SKIP: assert property (state == ST_BOOT && pin_n && mode == BOOT_SKIP
        |=> run_o && !ram_check_busy_o)
        else $error("skip mode did not branch at once");
    AST_PROHIB: assert property (state == ST_BOOT && pin_n && mode == BOOT_BAD
        |=> boot_error_o && !run_o)
        else $error("prohibited mode not refused");
    AST_CHECK_BOOT: assert property (ram_check_busy_o |-> host_boot_o || self_boot_o)
        else $error("ram check outside a boot");
    AST_SELF_PARAM: assert property (self_boot_o |-> boot_param_addr_o == BOOT_PARAM_ADDR
        && !host_boot_o)
        else $error("self boot parameter address wrong");
    AST_MULT: assert property (run_o && pll_ready_o |-> pll_mult_o == MULT_W'(PLL_MULT))
        else $error("run without fixed multiplier");
    AST_RELOAD: assert property ($rose(pll_init_o) |-> reload_needed_o)
        else $error("pll setup did not demand a reload");

    COV_PLL_PATH: cover property ($rose(pll_ready_o));
    COV_BOOT_RUN: cover property (host_boot_o ##1 !host_boot_o && run_o);
    COV_BAD: cover property ($rose(boot_error_o));

endmodule
`default_nettype wire

// ==== reset_pll_boot_sequencer_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module reset_pll_boot_sequencer_bench
    import reset_seq_pkg::*;
;
    localparam int CHECK_CYC = 60;
    localparam int MULT = 3;
    logic clk_i, rst_i, go, boot_done_i, strap_busy, reset_pin_n, sel_lo, sel_hi;
    logic [1:0] strap_mode;
    logic [15:0] strap_low;
    logic core_reset_o, mem_clear_o, pll_init_o, pll_lock_wait_o, pll_ready_o, release_violation_o;
    logic [MULT_W-1:0] pll_mult_o;
    logic [1:0] boot_mode_o;
    logic host_boot_o, self_boot_o, boot_error_o, reload_needed_o, ram_check_busy_o, ram_check_done_o, run_o;
    logic [15:0] boot_param_addr_o, pc_entry_o;
    int errors, checked, low_cnt, init_at, init_len, lock_len, chk_len;
    logic seen_pll, saw_clear;

    ////////////////////////////////////////////////////////////////////////////////
    // design and board model
    reset_pll_boot_sequencer #(.RAM_CHECK_CYC(CHECK_CYC), .PLL_MULT(MULT)) reset_pll_boot_sequencer_i (
        .clk_i(clk_i), .rst_i(rst_i), .reset_pin_n_i(reset_pin_n),
        .boot_select_low_pin_i(sel_lo), .boot_select_high_pin_i(sel_hi), .boot_done_i(boot_done_i),
        .core_reset_o(core_reset_o), .mem_clear_o(mem_clear_o), .pll_init_o(pll_init_o),
        .pll_lock_wait_o(pll_lock_wait_o), .pll_ready_o(pll_ready_o), .pll_mult_o(pll_mult_o),
        .release_violation_o(release_violation_o), .boot_mode_o(boot_mode_o), .host_boot_o(host_boot_o),
        .self_boot_o(self_boot_o), .boot_param_addr_o(boot_param_addr_o), .boot_error_o(boot_error_o),
        .reload_needed_o(reload_needed_o), .ram_check_busy_o(ram_check_busy_o),
        .ram_check_done_o(ram_check_done_o), .run_o(run_o), .pc_entry_o(pc_entry_o));
    board_reset_model board_reset_model_i (
        .clk_i(clk_i), .go_i(go), .mode_i(strap_mode), .low_clks_i(strap_low),
        .reset_pin_n_o(reset_pin_n), .boot_select_low_pin_o(sel_lo),
        .boot_select_high_pin_o(sel_hi), .busy_o(strap_busy));

    ////////////////////////////////////////////////////////////////////////////////
    // clock and phase length monitor
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        low_cnt <= (reset_pin_n === 1'b1) ? 0 : low_cnt + 1;
        if (pll_init_o === 1'b1 && init_len == 0) init_at <= low_cnt;
        if (pll_init_o === 1'b1) init_len <= init_len + 1;
        if (pll_init_o === 1'b1) seen_pll <= 1'b1;
        if (pll_lock_wait_o === 1'b1) lock_len <= lock_len + 1;
        if (ram_check_busy_o === 1'b1) chk_len <= chk_len + 1;
        if (mem_clear_o === 1'b1) saw_clear <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // compare helpers and waits
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_sig(input int which, input int lim);
        int n;
        n = 0;
        while (((which == 0) ? strap_busy === 1'b1 : run_o !== 1'b1) && n < lim) begin
            @(posedge clk_i);
            n++;
        end
        #1;
        if (n >= lim) chk(16'h0000, 16'h0001);
    endtask
    task automatic pulse_done();
        boot_done_i = 1'b1;
        @(posedge clk_i);
        #1 boot_done_i = 1'b0;
    endtask
    // reset pulse of given length and strap mode, ends after straps released
    task automatic start(input logic [1:0] mode, input logic [15:0] low);
        strap_mode = mode;
        strap_low = low;
        go = 1'b1;
        @(posedge clk_i);
        #1 go = 1'b0;
        {seen_pll, saw_clear} = 2'b00;
        {init_len, lock_len, chk_len} = '0;
        repeat (10) @(posedge clk_i);
        #1;
        chk(16'(core_reset_o), 16'h0001);
        chk(16'(run_o), 16'h0000);
        wait_sig(0, 5000);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_skip();
        start(2'b00, 16'h0014);
        chk(16'(seen_pll), 16'h0000);
        chk(16'(boot_mode_o), 16'h0000);
        chk(16'(run_o), 16'h0001);
        chk(pc_entry_o, RESET_ENTRY);
        chk(16'(ram_check_busy_o | ram_check_done_o), 16'h0000);
        $display("test skip done");
    endtask
    task automatic t_pll_self();
        start(2'b11, 16'h0C1C);
        chk(16'(init_at >= PLL_START_CLKS && init_at <= PLL_START_CLKS + 6), 16'h0001);
        chk(16'(init_len), 16'(PLL_INIT_CLKS));
        chk(16'(lock_len), 16'(PLL_LOCK_CYC));
        chk(16'(saw_clear), 16'h0001);
        chk(16'(pll_ready_o), 16'h0001);
        chk(16'(pll_mult_o), 16'(MULT));
        chk(16'(reload_needed_o), 16'h0001);
        chk(16'(boot_mode_o), 16'h0003);
        chk(16'(self_boot_o), 16'h0001);
        chk(boot_param_addr_o, BOOT_PARAM_ADDR);
        chk(16'(ram_check_busy_o), 16'h0001);
        pulse_done();
        wait_sig(1, 300);
        chk(16'(chk_len), 16'(CHECK_CYC));
        chk(16'(ram_check_done_o), 16'h0001);
        chk(pc_entry_o, RESET_ENTRY);
        chk(16'(reload_needed_o | self_boot_o), 16'h0000);
        $display("test pll self done");
    endtask
    task automatic t_host();
        start(2'b01, 16'h0014);
        chk(16'(boot_mode_o), 16'h0001);
        chk(16'(host_boot_o), 16'h0001);
        chk(16'(ram_check_busy_o), 16'h0001);
        repeat (100) @(posedge clk_i);
        #1;
        chk(16'(run_o), 16'h0000);
        chk(16'(ram_check_done_o), 16'h0001);
        pulse_done();
        wait_sig(1, 300);
        chk(pc_entry_o, RESET_ENTRY);
        chk(16'(seen_pll | pll_ready_o), 16'h0001);
        chk(16'(seen_pll), 16'h0000);
        $display("test host done");
    endtask
    task automatic t_bad();
        start(2'b10, 16'h0014);
        chk(16'(boot_error_o), 16'h0001);
        pulse_done();
        repeat (100) @(posedge clk_i);
        #1;
        chk(16'(run_o | host_boot_o | self_boot_o), 16'h0000);
        $display("test prohibited done");
    endtask
    task automatic t_early();
        start(2'b00, 16'h044C);
        chk(16'(seen_pll), 16'h0001);
        chk(16'(release_violation_o), 16'h0001);
        chk(16'(pll_ready_o), 16'h0000);
        chk(16'(reload_needed_o), 16'h0001);
        $display("test early release done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // verdict, watchdog and main sequence
    task automatic print_verdict();
        $display("checked=%0d errors=%0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        print_verdict();
    end
    initial begin
        {clk_i, rst_i, go, boot_done_i} = 4'b0100;
        {errors, checked, low_cnt, init_at} = '0;
        strap_mode = 2'b00;
        strap_low = 16'h0014;
        repeat (5) @(posedge clk_i);
        #1 rst_i = 1'b0;
        repeat (10) @(posedge clk_i);
        #1;
        t_skip();
        t_pll_self();
        t_host();
        t_bad();
        t_early();
        print_verdict();
    end
endmodule
`default_nettype wire

// ==== reset_seq_pkg.sv ====
`default_nettype none
package reset_seq_pkg;

    // input clock rate
    localparam int CLK_HZ = 10_000_000;

    // pll initialisation timing
    localparam int PLL_START_CLKS = 1024;
    localparam int PLL_INIT_CLKS = 1024;
    localparam int PLL_LOCK_US = 100;
    localparam int PLL_LOCK_CYC = (PLL_LOCK_US * CLK_HZ + 999_999) / 1_000_000;

    // data ram self-check: fixed number of operating clocks
    localparam int RAM_CHECK_MS = 20;
    localparam int RAM_CHECK_REF_MHZ = 50;
    localparam int RAM_CHECK_CYC_DEF = RAM_CHECK_MS * RAM_CHECK_REF_MHZ * 1000;

    // counter and multiplier widths, default multiplier
    localparam int CNT_W = 11;
    localparam int TMR_W = 20;
    localparam int MULT_W = 5;
    localparam int PLL_MULT_DEF = 1;

    // terminal counts
    localparam logic [CNT_W-1:0] PLL_START_LAST = CNT_W'(PLL_START_CLKS - 1);
    localparam logic [TMR_W-1:0] PLL_INIT_LAST = TMR_W'(PLL_INIT_CLKS - 1);
    localparam logic [TMR_W-1:0] PLL_LOCK_LAST = TMR_W'(PLL_LOCK_CYC - 1);

    // addresses
    localparam logic [15:0] RESET_ENTRY = 16'h0200;
    localparam logic [15:0] BOOT_PARAM_ADDR = 16'h4000;
    localparam logic [15:0] ADDR_NONE = 16'h0000;

    // boot mode pins, upper then lower
    typedef enum logic [1:0] {
        BOOT_SKIP = 2'b00,
        BOOT_HOST = 2'b01,
        BOOT_BAD = 2'b10,
        BOOT_SELF = 2'b11
    } boot_mode_t;

    // sequencer states
    typedef enum logic [2:0] {
        ST_COUNT = 3'b000,
        ST_PLL_INIT = 3'b001,
        ST_PLL_LOCK = 3'b010,
        ST_HOLD = 3'b011,
        ST_BOOT = 3'b100,
        ST_RUN = 3'b101,
        ST_BAD = 3'b110
    } seq_state_t;

endpackage
`default_nettype wire
